// >>> core/drive_digital_output_word.sv
// output control word register and switched output lines
`timescale 1ns/1ps
`default_nettype none

`include "dout_defines.svh"

module drive_digital_output_word
	import dout_pkg::*;
(
	input wire logic CORE_CLK_I, // core clock, 200 MHz
	input wire logic SYS_RST_I, // async reset, active high
	input wire logic RPD_WR_I, // receive process data write strobe
	input wire obj_index_t RPD_INDEX_I, // object index of the write
	input wire ctrl_word_t RPD_DATA_I, // write data
	input wire logic RD_REQ_I, // read request strobe
	input wire obj_index_t RD_INDEX_I, // object index of the read
	output logic RD_VALID_O, // read answer pulse
	output logic RD_ERR_O, // read hit no object
	output ctrl_word_t RD_DATA_O, // read answer data
	output logic WR_ERR_O, // write hit no object
	input wire assign_param_t OUTPUT_ASSIGN_PARAM_A_I, // assignment parameter a
	input wire assign_param_t OUTPUT_ASSIGN_PARAM_B_I, // assignment parameter b
	input wire assign_param_t OUTPUT_ASSIGN_PARAM_C_I, // assignment parameter c
	input wire line_vec_t ALT_LINE_I, // lines from other functions
	output logic OUTPUTS_FROM_WORD_O, // word selected; lines take the word bits from the next edge
	output logic SWITCHED_OUTPUT_LINE_1_O, // switched output line 1
	output logic SWITCHED_OUTPUT_LINE_2_O, // switched output line 2
	output logic SWITCHED_OUTPUT_LINE_3_O // switched output line 3
);

	// ====================================================================
	// object decode, used by write and read paths
	// one shared decoder keeps both paths agreeing on the mapped index
	function automatic logic hits_word(input obj_index_t idx);
		hits_word = (idx == `OCW_INDEX);
	endfunction

	ctrl_word_t word_r;
	ctrl_word_t word_nxt;
	logic rd_valid_r;
	logic rd_valid_nxt;
	logic rd_err_r;
	logic rd_err_nxt;
	ctrl_word_t rd_data_r;
	ctrl_word_t rd_data_nxt;
	logic wr_err_r;
	logic wr_err_nxt;
	logic wr_hit;
	logic rd_hit;
	logic follow;
	line_vec_t pins;

	dout_if link ();

	assign wr_hit = hits_word(RPD_INDEX_I);
	assign rd_hit = hits_word(RD_INDEX_I);

	// ====================================================================
	// word storage: all 16 bits kept for read back
	// the host reads back exactly what it wrote, though only three bits reach a pin
	always_comb
	begin
		word_nxt = word_r;
		wr_err_nxt = 1'b0;
		if (RPD_WR_I)
		begin
			if (wr_hit)
				word_nxt = RPD_DATA_I;
			else
				wr_err_nxt = 1'b1;
		end
	end

	// word and write error flops
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			word_r <= `OCW_RESET;
			wr_err_r <= 1'b0;
		end
		else
		begin
			word_r <= word_nxt;
			wr_err_r <= wr_err_nxt;
		end
	end

	// ====================================================================
	// read path: answer one cycle after the request
	// registered answer: a read beside a write in one cycle sees the old word
	always_comb
	begin
		rd_valid_nxt = RD_REQ_I;
		rd_err_nxt = RD_REQ_I && !rd_hit;
		rd_data_nxt = `OCW_ZERO_DATA;
		if (RD_REQ_I && rd_hit)
			rd_data_nxt = word_r;
	end

	// read answer flops
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			rd_valid_r <= 1'b0;
			rd_err_r <= 1'b0;
			rd_data_r <= `OCW_ZERO_DATA;
		end
		else
		begin
			rd_valid_r <= rd_valid_nxt;
			rd_err_r <= rd_err_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	// ====================================================================
	// line selection: only bits 2..0 go on to the line selector; the read path carries all 16
	// any nonzero parameter hands all three lines back, all or nothing
	always_comb
	begin
		follow = (OUTPUT_ASSIGN_PARAM_A_I == `ASSIGN_FOLLOW_WORD)
			&& (OUTPUT_ASSIGN_PARAM_B_I == `ASSIGN_FOLLOW_WORD)
			&& (OUTPUT_ASSIGN_PARAM_C_I == `ASSIGN_FOLLOW_WORD);
	end

	assign link.word_bits = word_r[`OCW_LINE_MSB:`OCW_LINE_LSB];
	assign link.alt_lines = ALT_LINE_I;
	assign link.follow = follow;

	line_select u_line_select (
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.link(link)
	);

	// ====================================================================
	// outputs
	assign RD_VALID_O = rd_valid_r;
	assign RD_ERR_O = rd_err_r;
	assign RD_DATA_O = rd_data_r;
	assign WR_ERR_O = wr_err_r;
	assign OUTPUTS_FROM_WORD_O = follow;
	assign SWITCHED_OUTPUT_LINE_1_O = link.lines[0];
	assign SWITCHED_OUTPUT_LINE_2_O = link.lines[1];
	assign SWITCHED_OUTPUT_LINE_3_O = link.lines[2];

	// pin levels gathered for the checks, line 1 in bit 0
	assign pins = {SWITCHED_OUTPUT_LINE_3_O, SWITCHED_OUTPUT_LINE_2_O,
		SWITCHED_OUTPUT_LINE_1_O};

	// ====================================================================
	// checks
	// every check is off while reset stands; reset values are checked
	// on the first edge after release
	a_write_stores: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		RPD_WR_I && wr_hit |=> word_r == $past(RPD_DATA_I))
		else $error("written word not stored");

	a_stray_write_kept: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		RPD_WR_I && !wr_hit |=> $stable(word_r) && WR_ERR_O)
		else $error("write to other object changed the word");

	a_read_back: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		RD_REQ_I && rd_hit |=> RD_VALID_O && !RD_ERR_O && RD_DATA_O == $past(word_r))
		else $error("read back differs from stored word");

	a_stray_read: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		RD_REQ_I && !rd_hit |=> RD_VALID_O && RD_ERR_O && RD_DATA_O == `OCW_ZERO_DATA)
		else $error("unmapped read not flagged");

	a_high_ignored: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		(RPD_WR_I && wr_hit && follow
			&& RPD_DATA_I[`OCW_LINE_MSB:`OCW_LINE_LSB] == word_r[`OCW_LINE_MSB:`OCW_LINE_LSB])
			##1 follow
		|=> $stable(link.lines))
		else $error("upper word bits moved an output line");

	a_reset_off: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		$fell(SYS_RST_I) |-> word_r == `OCW_RESET && link.lines == `LINES_OFF)
		else $error("word or lines not cleared by reset");

	// pins carry the word's low bits, line 1 from bit 0
	a_lines_at_pins: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		follow |=> pins == $past(word_r[`OCW_LINE_MSB:`OCW_LINE_LSB]))
		else $error("pin levels differ from the word bits");

	// pins carry the other functions while the word is not selected
	a_alt_at_pins: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		!follow |=> pins == $past(ALT_LINE_I))
		else $error("pin levels differ from their other functions");

	// upper and reserved bits never move a pin
	a_upper_bits_inert: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		follow && $past(follow)
		&& $stable(word_r[`OCW_LINE_MSB:`OCW_LINE_LSB]) |=> $stable(pins))
		else $error("a pin moved while the low word bits held");

	// the write error flag only answers an unmapped write
	a_wr_err_cause: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		!(RPD_WR_I && !wr_hit) |=> !WR_ERR_O)
		else $error("write error without an unmapped write");

	// the word only changes on a mapped write
	a_word_holds: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		!(RPD_WR_I && wr_hit) |=> $stable(word_r))
		else $error("word changed without a mapped write");

	// no answer and zero data without a request
	a_read_idle: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		!RD_REQ_I |=> !RD_VALID_O && !RD_ERR_O && RD_DATA_O == `OCW_ZERO_DATA)
		else $error("read answer without a request");

	// an error answer is a valid answer with zero data
	a_err_data_zero: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		RD_ERR_O |-> RD_VALID_O && RD_DATA_O == `OCW_ZERO_DATA)
		else $error("read error answer carries data");

	// pins themselves are off right after reset
	a_reset_pins: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		$fell(SYS_RST_I) |-> pins == `LINES_OFF)
		else $error("pins not off after reset");

endmodule

`default_nettype wire

// >>> pkg/dout_defines.svh
// constants for the output control word block
`ifndef DOUT_DEFINES_SVH
`define DOUT_DEFINES_SVH

// ====================================================================
// word location and reset value
`define OCW_INDEX 16'h2522
`define OCW_RESET 16'h0000
`define OCW_ZERO_DATA 16'h0000

// ====================================================================
// field positions
`define OCW_LINE_LSB 0
`define OCW_LINE_MSB 2
`define OCW_LINE_CNT 3

// ====================================================================
// assignment parameter value that hands a line to the word
`define ASSIGN_FOLLOW_WORD 4'h0
`define LINES_OFF 3'h0

`endif

// >>> pkg/dout_pkg.sv
// types shared by the output control word block
package dout_pkg;

	// ====================================================================
	// data types
	typedef logic [15:0] ctrl_word_t;
	typedef logic [15:0] obj_index_t;
	typedef logic [3:0] assign_param_t;
	typedef logic [2:0] line_vec_t;

endpackage

// >>> pkg/dout_if.sv
// link between the word register and the line selector
`timescale 1ns/1ps
`default_nettype none

interface dout_if;
	import dout_pkg::*;

	// ====================================================================
	// carried signals
	line_vec_t word_bits; // low three bits of the control word
	line_vec_t alt_lines; // lines from their other assigned functions
	logic follow; // lines follow the word
	line_vec_t lines; // registered line levels

	modport ctl (output word_bits, output alt_lines, output follow, input lines);
	modport sel (input word_bits, input alt_lines, input follow, output lines);

endinterface

`default_nettype wire

// >>> core/line_select.sv
// registered selector for the three switched output lines
`timescale 1ns/1ps
`default_nettype none

`include "dout_defines.svh"

module line_select
	import dout_pkg::*;
(
	input wire logic clk_i, // core clock
	input wire logic rst_i, // async reset, active high
	dout_if.sel link // word bits, alternates, select
);

	line_vec_t line_r;
	line_vec_t line_nxt;

	// ====================================================================
	// per-line choice between word bit and other function
	genvar g;
	generate
		for (g = 0; g < `OCW_LINE_CNT; g = g + 1)
		begin : gen_line
			always_comb
			begin
				line_nxt[g] = link.follow ? link.word_bits[g] : link.alt_lines[g];
			end
		end
	endgenerate

	// line flops, off from reset
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			line_r <= `LINES_OFF;
		else
			line_r <= line_nxt;
	end

	assign link.lines = line_r;

	// ====================================================================
	// checks
	a_line_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		link.follow |=> line_r == $past(link.word_bits))
		else $error("line does not follow its word bit");

	a_line_alt: assert property (@(posedge clk_i) disable iff (rst_i)
		!link.follow |=> line_r == $past(link.alt_lines))
		else $error("line left its other function while word not selected");

endmodule

`default_nettype wire

// >>> sim/host_model.sv
// host controller model that writes and reads the output control word
`timescale 1ns/1ps
`default_nettype none

module host_model
	import dout_pkg::*;
(
	input wire logic clk_i, // core clock
	input wire logic wr_err_i, // unmapped write flag
	output logic wr_o, // write strobe
	output obj_index_t wr_idx_o, // write index
	output ctrl_word_t wr_data_o, // write data
	output logic rd_o, // read strobe
	output obj_index_t rd_idx_o // read index
);
	// ====================================================================
	// bus tasks, all driven on the falling edge
	initial
	begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		wr_idx_o = 16'h0000;
		wr_data_o = 16'h0000;
		rd_idx_o = 16'h0000;
	end

	// one-cycle write; idle index and data are inverted, not left stale
	task wr(input obj_index_t idx, input ctrl_word_t d, output logic err);
		@(negedge clk_i);
		wr_o = 1'b1;
		wr_idx_o = idx;
		wr_data_o = {d[15:8], 5'h00, d[2:0]};
		@(negedge clk_i);
		err = wr_err_i;
		wr_o = 1'b0;
		wr_idx_o = ~idx;
		wr_data_o = ~wr_data_o;
	endtask

	// one-cycle read request
	task rd(input obj_index_t idx);
		@(negedge clk_i);
		rd_o = 1'b1;
		rd_idx_o = idx;
		@(negedge clk_i);
		rd_o = 1'b0;
		rd_idx_o = ~idx;
	endtask
endmodule

`default_nettype wire

// >>> sim/drive_digital_output_word_tb_top.sv
// testbench for the output control word block
`timescale 1ns/1ps
`default_nettype none

`include "dout_defines.svh"

module drive_digital_output_word_tb_top
	import dout_pkg::*;
;
	// ====================================================================
	// stimulus, host model, read monitor
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr, rd, werr, rv, re, ofw;
	obj_index_t wi, ri, bad;
	ctrl_word_t wd, rdd, w, d;
	assign_param_t pa = 4'h0, pb = 4'h0, pc = 4'h0, p;
	line_vec_t alt = 3'h0;
	wire logic [2:0] ln;
	logic [16:0] rq[$];
	logic [16:0] x;
	int failures = 0;
	int n_compared = 0;

	always #2.5 clk = ~clk;

	host_model host (.clk_i(clk), .wr_err_i(werr), .wr_o(wr), .wr_idx_o(wi),
		.wr_data_o(wd), .rd_o(rd), .rd_idx_o(ri));

	drive_digital_output_word DUT (.CORE_CLK_I(clk), .SYS_RST_I(rst), .RPD_WR_I(wr),
		.RPD_INDEX_I(wi), .RPD_DATA_I(wd), .RD_REQ_I(rd), .RD_INDEX_I(ri),
		.RD_VALID_O(rv), .RD_ERR_O(re), .RD_DATA_O(rdd), .WR_ERR_O(werr),
		.OUTPUT_ASSIGN_PARAM_A_I(pa), .OUTPUT_ASSIGN_PARAM_B_I(pb),
		.OUTPUT_ASSIGN_PARAM_C_I(pc), .ALT_LINE_I(alt), .OUTPUTS_FROM_WORD_O(ofw),
		.SWITCHED_OUTPUT_LINE_1_O(ln[0]), .SWITCHED_OUTPUT_LINE_2_O(ln[1]),
		.SWITCHED_OUTPUT_LINE_3_O(ln[2]));

	// ====================================================================
	// compare tasks, one per kind of result
	task automatic chk_word(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_lines(input string nm, input logic [2:0] exp, input logic [2:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
		end
	endtask

	task automatic chk_flag(input string nm, input logic exp, input logic got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
		end
	endtask

	// ====================================================================
	// driver helpers: a read notes what is expected, then drives; a write drives, then checks
	task automatic read_exp(input obj_index_t idx, input logic err, input ctrl_word_t exp);
		rq.push_back({err, exp});
		host.rd(idx);
	endtask

	// write through the host and keep the shadow word
	task automatic write_exp(input obj_index_t idx, input ctrl_word_t dat);
		logic err;
		host.wr(idx, dat, err);
		chk_flag("write error", idx != `OCW_INDEX, err);
		if (idx == `OCW_INDEX)
			w = {dat[15:8], 5'h00, dat[2:0]};
	endtask

	// let one edge pass, then compare follow flag and pins
	task automatic lines_exp(input logic fol, input line_vec_t exp);
		@(negedge clk);
		chk_flag("follow flag", fol, ofw);
		chk_lines("switched lines", exp, ln);
	endtask

	// ====================================================================
	// read monitor: each answer takes the oldest note off the queue
	always @(negedge clk)
	begin
		if (rv !== 1'b0)
		begin
			if (rq.size() == 0)
			begin
				failures++;
				$display("CHECK FAILED read answer expected none seen %h", rdd);
			end
			else
			begin
				x = rq.pop_front();
				chk_flag("read error", x[16], re);
				chk_word("read data", x[15:0], rdd);
			end
		end
	end

	// ====================================================================
	// verdict: counts, then pass or fail
	task automatic give_verdict();
		if (rq.size() != 0)
			failures++;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ====================================================================
	// watchdog: the sequence needs under 400 cycles, allow 20000
	initial
	begin
		#100000;
		failures++;
		$display("watchdog expired before the tests ended");
		give_verdict();
	end

	// ====================================================================
	// test sequence, all inputs changed at the falling edge
	initial
	begin
		void'($urandom(31));
		repeat (5) @(negedge clk);
		rst = 1'b0;
		// word and lines clear from reset
		lines_exp(1'b1, `LINES_OFF);
		read_exp(`OCW_INDEX, 1'b0, `OCW_RESET);
		w = `OCW_RESET;
		// all on, then upper bits alone, then random words
		write_exp(`OCW_INDEX, 16'h0007);
		lines_exp(1'b1, 3'h7);
		write_exp(`OCW_INDEX, 16'hFF00);
		lines_exp(1'b1, 3'h0);
		read_exp(`OCW_INDEX, 1'b0, 16'hFF00);
		for (int i = 0; i < 24; i++)
		begin
			d = 16'($urandom);
			write_exp(`OCW_INDEX, d);
			lines_exp(1'b1, w[`OCW_LINE_MSB:`OCW_LINE_LSB]);
			read_exp(`OCW_INDEX, 1'b0, w);
		end
		// unmapped index: error pulses, word and lines kept
		bad = 16'($urandom);
		if (bad == `OCW_INDEX)
			bad = ~bad;
		write_exp(bad, ~w);
		lines_exp(1'b1, w[`OCW_LINE_MSB:`OCW_LINE_LSB]);
		read_exp(bad, 1'b1, `OCW_ZERO_DATA);
		read_exp(`OCW_INDEX, 1'b0, w);
		// any nonzero parameter hands the lines to their other functions
		for (int k = 0; k < 3; k++)
		begin
			p = 4'($urandom_range(15, 1));
			pa = (k == 0) ? p : `ASSIGN_FOLLOW_WORD;
			pb = (k == 1) ? p : `ASSIGN_FOLLOW_WORD;
			pc = (k == 2) ? p : `ASSIGN_FOLLOW_WORD;
			alt = 3'($urandom);
			lines_exp(1'b0, alt);
			write_exp(`OCW_INDEX, ~w);
			lines_exp(1'b0, alt);
			read_exp(`OCW_INDEX, 1'b0, w);
		end
		pa = `ASSIGN_FOLLOW_WORD;
		pb = `ASSIGN_FOLLOW_WORD;
		pc = `ASSIGN_FOLLOW_WORD;
		alt = ~alt;
		lines_exp(1'b1, w[`OCW_LINE_MSB:`OCW_LINE_LSB]);
		// a read beside a write in one cycle sees the old word
		d = 16'($urandom);
		fork
			read_exp(`OCW_INDEX, 1'b0, w);
			write_exp(`OCW_INDEX, d);
		join
		lines_exp(1'b1, w[`OCW_LINE_MSB:`OCW_LINE_LSB]);
		// second reset in mid-run clears word and lines again
		@(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		chk_lines("lines in reset", `LINES_OFF, ln);
		@(negedge clk);
		rst = 1'b0;
		w = `OCW_RESET;
		lines_exp(1'b1, `LINES_OFF);
		read_exp(`OCW_INDEX, 1'b0, w);
		@(negedge clk);
		give_verdict();
	end
endmodule
`default_nettype wire
